// ==== src/gcr_pkg.sv ====
// shared constants and types of the cardiac/respiratory gating trigger
package gcr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_HOLD   = 8'h08;
  localparam logic [7:0] OFS_BLANK  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CTL_EN    = 0;
  localparam int CTL_CPOL  = 1;
  localparam int CTL_RPOL  = 2;
  localparam int CTL_LARGE = 3;
  localparam int STS_QUIET = 0;
  localparam int STS_DONE  = 1;
  localparam int STS_CNT   = 4;
  localparam int STS_TRIG  = 8;
  localparam int STS_BLANK = 9;

  localparam int CNT_W   = 3;
  localparam int HOLD_W  = 8;
  localparam int BLANK_W = 11;
  localparam int TMR_W   = 16;

  localparam logic [3:0]         CTRL_RST  = 4'h0;
  localparam logic [CNT_W-1:0]   CNT_RST   = 3'h0;
  localparam logic [HOLD_W-1:0]  HOLD_RST  = 8'h01;
  localparam logic [BLANK_W-1:0] BLANK_RST = 11'h032;

  // ****************************************************************
  // timing, all timers share one tick resolution
  // ****************************************************************
  localparam int CLK_KHZ      = 125000;
  localparam int TICK_US      = 100;
  localparam int TICK_CYC     = TICK_US * CLK_KHZ / 1000;
  localparam int TICKS_PER_MS = 1000 / TICK_US;
  localparam int WIN_MS       = 100;
  localparam int PULSE_US     = 500;
  localparam logic [TMR_W-1:0] WIN_TICKS   = TMR_W'(WIN_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] PULSE_TICKS = TMR_W'((PULSE_US + TICK_US - 1) / TICK_US);

  localparam logic [TMR_W-1:0] HOLD_MIN_S  = 16'h0001;
  localparam logic [TMR_W-1:0] HOLD_MAX_S  = 16'h0032;
  localparam logic [TMR_W-1:0] HOLD_MIN_L  = 16'h0005;
  localparam logic [TMR_W-1:0] HOLD_MAX_L  = 16'h00fa;
  localparam logic [TMR_W-1:0] BLANK_MIN_S = 16'h0032;
  localparam logic [TMR_W-1:0] BLANK_MAX_S = 16'h012c;
  localparam logic [TMR_W-1:0] BLANK_MIN_L = 16'h00fa;
  localparam logic [TMR_W-1:0] BLANK_MAX_L = 16'h05dc;

  localparam int NUM_TMR   = 4;
  localparam int TMR_WIN   = 0;
  localparam int TMR_HOLD  = 1;
  localparam int TMR_BLANK = 2;
  localparam int TMR_PULSE = 3;

  typedef enum logic [5:0] {
    S_OUT   = 6'h01,
    S_WIN   = 6'h02,
    S_ARM   = 6'h04,
    S_HOLD  = 6'h08,
    S_PULSE = 6'h10,
    S_DONE  = 6'h20
  } gcr_state_t;
endpackage

// ==== src/gcr_tmr_if.sv ====
// start/length/done bundle between the gating core and its timers
`timescale 1ns/1ps
`default_nettype none
interface gcr_tmr_if;
  logic                      start;
  logic [gcr_pkg::TMR_W-1:0] len;
  logic                      busy;
  logic                      done;
  modport ctl (output start, output len, input busy, input done);
  modport tmr (input start, input len, output busy, output done);
endinterface
`default_nettype wire

// ==== src/gcr_edge.sv ====
// polarity select and edge detection of one threshold square wave
`timescale 1ns/1ps
`default_nettype none
module gcr_edge
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic wave,
  input  wire logic pol,
  output logic      lvl,
  output logic      lead,
  output logic      trail
);
  logic lvl_r;
  logic prev_r;
  logic primed_r;

  // first sample loads both stages so reset never fakes an edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lvl_r    <= 1'b0;
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
    end
    else
    begin
      lvl_r    <= wave ^ pol;
      prev_r   <= primed_r ? lvl_r : (wave ^ pol);
      primed_r <= 1'b1;
    end
  end

  assign lvl   = lvl_r;
  assign lead  = lvl_r & ~prev_r;
  assign trail = ~lvl_r & prev_r;
endmodule
`default_nettype wire

// ==== src/gcr_timer.sv ====
// tick-prescaled one-shot interval timer
`timescale 1ns/1ps
`default_nettype none
module gcr_timer
#(
  parameter int TICK_CYCLES = gcr_pkg::TICK_CYC
)
(
  input  wire logic clk,
  input  wire logic reset,
  gcr_tmr_if.tmr    t
);
  import gcr_pkg::*;

  logic [31:0]      pre_r;
  logic [TMR_W-1:0] left_r;
  logic [TMR_W-1:0] len_r;
  logic             busy_r;
  logic             tick;
  logic [31:0]      el_r;

  // prescaler restarts on every start, so lengths are exact in cycles
  assign tick   = busy_r && (pre_r == 32'(TICK_CYCLES - 1));
  assign t.busy = busy_r;
  assign t.done = tick && (left_r == TMR_W'(1));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_r <= 1'b0;
      pre_r  <= 32'h0;
      left_r <= '0;
      len_r  <= '0;
    end
    else if (t.start)
    begin
      busy_r <= (t.len != '0);
      pre_r  <= 32'h0;
      left_r <= t.len;
      len_r  <= t.len;
    end
    else if (busy_r)
    begin
      pre_r <= tick ? 32'h0 : pre_r + 32'h1;
      if (tick)
      begin
        left_r <= left_r - TMR_W'(1);
        busy_r <= (left_r != TMR_W'(1));
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || t.start)
      el_r <= 32'h1;
    else if (busy_r)
      el_r <= el_r + 32'h1;
  end

  chk_timer_length: assert property (@(posedge clk) disable iff (reset)
    t.done |-> el_r == 32'(len_r) * 32'(TICK_CYCLES))
    else $error("timer interval not len times tick");
endmodule
`default_nettype wire

// ==== src/gcr_gate.sv ====
// cardiac/respiratory gated mri trigger with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Function
// - cardiac triggers leave only while respiration is in its quiet period
// - at most the set count of triggers per quiet period, count 1 to 8
// - cardiac edges within 100 ms of quiet entry are ignored
// - quiet end drops remaining triggers; next quiet period counts from zero
// - each mri trigger is low for exactly 500 us, then high
// - per channel polarity picks rising or falling crossing as active
// - accepted cardiac edge delayed by hold-off, range set by variant
// - blanking rejects cardiac events, range set by variant
// - cardiac and respiration square waves repeated on monitor outputs
// - hold-off runs from the active cardiac edge to the pulse start
// - blanking starts on the trailing edge of an accepted cardiac event
// - quiet period is rise-to-fall or fall-to-rise of respiration
// ****************************************************************
module gcr_gate
#(
  parameter int TICK_CYCLES = gcr_pkg::TICK_CYC
)
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [gcr_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [gcr_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [gcr_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [gcr_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        cardiac_square_wave,
  input  wire logic                        respiration_square_wave,
  output logic                             mri_trig_n,
  output logic                             cardiac_mon,
  output logic                             respiration_mon
);
  import gcr_pkg::*;

  // ****************************************************************
  // configuration and bus state
  // ****************************************************************
  logic [3:0]         ctrl_r;
  logic [CNT_W-1:0]   cnt_m1_r;
  logic [HOLD_W-1:0]  hold_ms_r;
  logic [BLANK_W-1:0] blank_ms_r;
  logic               aw_got_r;
  logic               w_got_r;
  logic [ADDR_W-1:0]  aw_addr_r;
  logic [DATA_W-1:0]  wdata_r;
  logic [3:0]         wstrb_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               rvalid_r;
  logic [1:0]         rresp_r;
  logic [DATA_W-1:0]  rdata_r;
  logic               do_wr;
  logic [DATA_W-1:0]  wr_word;
  logic [DATA_W-1:0]  status_w;

  gcr_state_t         state_r;
  logic [3:0]         emitted_r;
  logic               blank_pend_r;
  logic               trig_n_r;
  logic               card_mon_r;
  logic               resp_mon_r;
  logic               quiet;
  logic               q_entry;
  logic               c_act;
  logic               c_trail;
  logic               leave;
  logic               accept;
  logic               pulse_go;
  logic [3:0]         target;
  logic [TMR_W-1:0]   hold_len;
  logic [TMR_W-1:0]   blank_len;

  // declared ahead of the status mux and sequencer that read it
  gcr_tmr_if tif[NUM_TMR] ();

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a inside {OFS_CTRL, OFS_COUNT, OFS_HOLD, OFS_BLANK, OFS_STATUS};
  endfunction

  function automatic logic [DATA_W-1:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = '0;
    case (a)
      OFS_CTRL:   v[3:0] = ctrl_r;
      OFS_COUNT:  v[CNT_W-1:0] = cnt_m1_r;
      OFS_HOLD:   v[HOLD_W-1:0] = hold_ms_r;
      OFS_BLANK:  v[BLANK_W-1:0] = blank_ms_r;
      OFS_STATUS: v = status_w;
      default:    v = '0;
    endcase
    return v;
  endfunction

  // out-of-range settings saturate instead of being refused
  function automatic logic [TMR_W-1:0] clamp_ticks(input logic [TMR_W-1:0] ms,
                                                   input logic [TMR_W-1:0] lo,
                                                   input logic [TMR_W-1:0] hi);
    logic [TMR_W-1:0] c;
    c = (ms < lo) ? lo : ((ms > hi) ? hi : ms);
    return TMR_W'(c * TMR_W'(TICKS_PER_MS));
  endfunction

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign do_wr         = aw_got_r && w_got_r && !bvalid_r;

  always_comb
  begin
    wr_word = rd_mux(aw_addr_r);
    for (int i = 0; i < 4; i++)
      if (wstrb_r[i])
        wr_word[8*i +: 8] = wdata_r[8*i +: 8];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      wdata_r   <= '0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= rd_mux(s_axi_araddr);
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_r     <= CTRL_RST;
      cnt_m1_r   <= CNT_RST;
      hold_ms_r  <= HOLD_RST;
      blank_ms_r <= BLANK_RST;
    end
    else if (do_wr)
    begin
      case (aw_addr_r)
        OFS_CTRL:  ctrl_r <= wr_word[3:0];
        OFS_COUNT: cnt_m1_r <= wr_word[CNT_W-1:0];
        OFS_HOLD:  hold_ms_r <= wr_word[HOLD_W-1:0];
        OFS_BLANK: blank_ms_r <= wr_word[BLANK_W-1:0];
        default:   ;
      endcase
    end
  end

  always_comb
  begin
    status_w                      = '0;
    status_w[STS_QUIET]           = quiet;
    status_w[STS_DONE]            = (state_r == S_DONE);
    status_w[STS_CNT +: 4]        = emitted_r;
    status_w[STS_TRIG]            = !trig_n_r;
    status_w[STS_BLANK]           = tif[TMR_BLANK].busy || blank_pend_r;
  end

  // ****************************************************************
  // channel front ends and timers
  // ****************************************************************
  gcr_edge u_card
  (
    .clk   (clk),
    .reset (reset),
    .wave  (cardiac_square_wave),
    .pol   (ctrl_r[CTL_CPOL]),
    .lvl   (),
    .lead  (c_act),
    .trail (c_trail)
  );

  // quiet runs from the selected respiration edge to the opposite one
  gcr_edge u_resp
  (
    .clk   (clk),
    .reset (reset),
    .wave  (respiration_square_wave),
    .pol   (ctrl_r[CTL_RPOL]),
    .lvl   (quiet),
    .lead  (q_entry),
    .trail ()
  );

  for (genvar g = 0; g < NUM_TMR; g++)
  begin : g_tmr
    gcr_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tmr
    (
      .clk   (clk),
      .reset (reset),
      .t     (tif[g])
    );
  end

  assign hold_len  = ctrl_r[CTL_LARGE] ?
                     clamp_ticks(TMR_W'(hold_ms_r), HOLD_MIN_L, HOLD_MAX_L) :
                     clamp_ticks(TMR_W'(hold_ms_r), HOLD_MIN_S, HOLD_MAX_S);
  assign blank_len = ctrl_r[CTL_LARGE] ?
                     clamp_ticks(TMR_W'(blank_ms_r), BLANK_MIN_L, BLANK_MAX_L) :
                     clamp_ticks(TMR_W'(blank_ms_r), BLANK_MIN_S, BLANK_MAX_S);

  // ****************************************************************
  // gating sequencer
  // ****************************************************************
  assign leave    = !quiet || !ctrl_r[CTL_EN];
  assign target   = 4'(cnt_m1_r) + 4'h1;
  assign accept   = (state_r == S_ARM) && !leave && c_act && !blank_pend_r
                    && !tif[TMR_BLANK].busy;
  assign pulse_go = (state_r == S_HOLD) && !leave && tif[TMR_HOLD].done;

  assign tif[TMR_WIN].start   = (state_r == S_OUT) && ctrl_r[CTL_EN] && q_entry;
  assign tif[TMR_WIN].len     = WIN_TICKS;
  assign tif[TMR_HOLD].start  = accept;
  assign tif[TMR_HOLD].len    = hold_len;
  assign tif[TMR_BLANK].start = blank_pend_r && c_trail;
  assign tif[TMR_BLANK].len   = blank_len;
  assign tif[TMR_PULSE].start = pulse_go;
  assign tif[TMR_PULSE].len   = PULSE_TICKS;

  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= S_OUT;
    else
    begin
      unique case (state_r)
        S_OUT:   if (tif[TMR_WIN].start) state_r <= S_WIN;
        S_WIN:   if (leave) state_r <= S_OUT;
                 else if (tif[TMR_WIN].done) state_r <= S_ARM;
        S_ARM:   if (leave) state_r <= S_OUT;
                 else if (accept) state_r <= S_HOLD;
        S_HOLD:  if (leave) state_r <= S_OUT;
                 else if (pulse_go) state_r <= S_PULSE;
        // a started pulse always completes its full width
        S_PULSE: if (tif[TMR_PULSE].done)
                   state_r <= leave ? S_OUT : ((emitted_r >= target) ? S_DONE : S_ARM);
        S_DONE:  if (leave) state_r <= S_OUT;
        default: state_r <= S_OUT;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || tif[TMR_WIN].start)
      emitted_r <= 4'h0;
    else if (pulse_go)
      emitted_r <= emitted_r + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset || tif[TMR_WIN].start)
      blank_pend_r <= 1'b0;
    else if (accept)
      blank_pend_r <= 1'b1;
    else if (c_trail)
      blank_pend_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      trig_n_r <= 1'b1;
    else if (pulse_go)
      trig_n_r <= 1'b0;
    else if (tif[TMR_PULSE].done)
      trig_n_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      card_mon_r <= 1'b0;
      resp_mon_r <= 1'b0;
    end
    else
    begin
      card_mon_r <= cardiac_square_wave;
      resp_mon_r <= respiration_square_wave;
    end
  end

  assign mri_trig_n      = trig_n_r;
  assign cardiac_mon     = card_mon_r;
  assign respiration_mon = resp_mon_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [31:0]      low_cnt_r;
  logic [31:0]      hold_cnt_r;
  logic [31:0]      since_r;
  logic [TMR_W-1:0] hold_lat_r;

  always_ff @(posedge clk)
  begin
    low_cnt_r  <= trig_n_r ? 32'h0 : low_cnt_r + 32'h1;
    hold_cnt_r <= accept ? 32'h1 : hold_cnt_r + 32'h1;
    hold_lat_r <= accept ? hold_len : hold_lat_r;
    if (tif[TMR_WIN].start)
      since_r <= 32'h1;
    else if (~&since_r)
      since_r <= since_r + 32'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_trig_in_quiet: assert property ($fell(trig_n_r) |-> $past(quiet))
    else $error("trigger started outside quiet period");
  chk_count_limit: assert property (pulse_go |-> emitted_r < target)
    else $error("more triggers than configured count");
  chk_window_gap: assert property (accept |->
    since_r > 32'(WIN_TICKS) * 32'(TICK_CYCLES))
    else $error("cardiac edge accepted inside 100 ms window");
  chk_drop_on_exit: assert property ((leave && state_r != S_PULSE) |=>
    state_r == S_OUT)
    else $error("sequence kept running after quiet ended");
  chk_pulse_width: assert property ($rose(trig_n_r) |->
    low_cnt_r == 32'(PULSE_TICKS) * 32'(TICK_CYCLES))
    else $error("trigger pulse width wrong");
  chk_holdoff_time: assert property ($fell(trig_n_r) |->
    hold_cnt_r == 32'(hold_lat_r) * 32'(TICK_CYCLES) + 32'h1)
    else $error("hold-off delay wrong");
  chk_blank_reject: assert property (tif[TMR_BLANK].busy |-> !accept)
    else $error("cardiac edge accepted during blanking");
  chk_blank_start: assert property ($rose(tif[TMR_BLANK].busy) |->
    $past(c_trail) && $past(blank_pend_r))
    else $error("blanking not started by trailing edge");
  chk_done_hold: assert property (state_r == S_DONE |=>
    state_r inside {S_DONE, S_OUT} && trig_n_r)
    else $error("trigger after full count");
endmodule
`default_nettype wire

// ==== tb/gcr_scanner_model.sv ====
// scanner trigger input model: counts low pulses and their width
`timescale 1ns/1ps
`default_nettype none
module gcr_scanner_model
(
  input  wire logic clk,
  input  wire logic trig_n,
  output int        pulses,
  output int        width
);
  int run = 0;
  // a pulse is counted once it ends, so its full width is known
  always @(posedge clk)
    if (trig_n === 1'b0)
      run++;
    else if (run != 0)
    begin
      pulses++;
      width = run;
      run = 0;
    end
endmodule
`default_nettype wire

// ==== tb/gcr_gate_tb.sv ====
// self-checking bench for the gated mri trigger
`timescale 1ns/1ps
`default_nettype none
module gcr_gate_tb;
  import gcr_pkg::*;
  localparam int TC  = 4;
  localparam int MS  = TICKS_PER_MS * TC;
  localparam int WIN = WIN_TICKS * TC;
  // longer than the small blanking time, so in the small-variant rows only the count or the number of edges limits pulses
  localparam int GAP = 2100;
  typedef struct { logic [3:0] ctrl; int cnt, hold, blank, edges, np, hms; } gcr_row_t;
  gcr_row_t    rows [5] = '{'{4'h1, 1, 1, 50, 2, 1, 1}, '{4'h3, 3, 3, 50, 2, 2, 3},
                            '{4'h5, 8, 2, 50, 9, 8, 2}, '{4'h9, 2, 1, 50, 3, 1, 5},
                            '{4'h1, 1, 255, 50, 1, 1, 50}};
  logic [7:0]  rst_a [4] = '{OFS_CTRL, OFS_COUNT, OFS_HOLD, OFS_BLANK};
  logic [31:0] rst_v [4] = '{32'(CTRL_RST), 32'(CNT_RST), 32'(HOLD_RST), 32'(BLANK_RST)};
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        cardiac_square_wave = 0, respiration_square_wave = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        mri_trig_n, cardiac_mon, respiration_mon;
  int          n_mismatch = 0, tests_run = 0, pulses, width;

  always #4 clk = ~clk;

  gcr_gate #(.TICK_CYCLES(TC)) u_gcr_gate
  (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cardiac_square_wave,
    .respiration_square_wave, .mri_trig_n, .cardiac_mon, .respiration_mon
  );

  gcr_scanner_model u_gcr_scanner_model (.clk, .trig_n(mri_trig_n), .pulses, .width);

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_int(input string nm, input int e, input int g);
    tests_run++;
    if (e != g)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one transfer; each valid drops at the edge its ready is seen
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] rs);
    bit ad, wd;
    int t;
    ad = 1'b0;
    wd = !wr;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    while (!(ad && wd) && t < 50)
    begin
      @(posedge clk);
      t++;
      ad = ad || (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      wd = wd || (s_axi_wvalid && s_axi_wready);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    while (!(wr ? s_axi_bvalid : s_axi_rvalid) && t < 100)
    begin
      @(posedge clk);
      t++;
    end
    rs = wr ? s_axi_bresp : s_axi_rresp;
    q = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (t >= 100) chk_int("axi_timeout", 0, t);
  endtask

  // one cardiac event; exp_d is the edge count to the pulse, 0 for none
  task automatic cyc(input logic act, input int exp_d, input int high, input int gap);
    int d;
    d = 0;
    cardiac_square_wave <= act;
    for (int k = 1; k <= high; k++)
    begin
      @(posedge clk);
      #1;
      if (k == 2) chk_bus("cardiac_mon", 32'(act), 32'(cardiac_mon));
      if (d == 0 && mri_trig_n === 1'b0) d = k;
    end
    chk_int("hold_delay", exp_d, d);
    @(posedge clk);
    cardiac_square_wave <= !act;
    repeat (gap) @(posedge clk);
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    gcr_row_t    r;
    logic [31:0] q;
    logic [1:0]  rs;
    int          n0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    foreach (rst_a[i])
    begin
      axi(1'b0, rst_a[i], 32'h0, q, rs);
      chk_bus("reset_value", rst_v[i], q);
    end
    foreach (rows[i])
    begin
      r = rows[i];
      // disable first so level changes for the new polarity are not taken
      axi(1'b1, OFS_CTRL, 32'h0, q, rs);
      cardiac_square_wave <= r.ctrl[1];
      respiration_square_wave <= r.ctrl[2];
      axi(1'b1, OFS_COUNT, 32'(r.cnt - 1), q, rs);
      axi(1'b1, OFS_HOLD, 32'(r.hold), q, rs);
      axi(1'b1, OFS_BLANK, 32'(r.blank), q, rs);
      axi(1'b1, OFS_CTRL, 32'(r.ctrl), q, rs);
      n0 = pulses;
      respiration_square_wave <= !r.ctrl[2];
      repeat (WIN / 2) @(posedge clk);
      cyc(!r.ctrl[1], 0, 100, WIN / 2);
      for (int k = 0; k < r.edges; k++)
        cyc(!r.ctrl[1], k < r.np ? r.hms * MS + 2 : 0, r.hms * MS + 100, GAP);
      respiration_square_wave <= r.ctrl[2];
      cyc(!r.ctrl[1], 0, 100, 100);
      chk_bus("respiration_mon", 32'(r.ctrl[2]), 32'(respiration_mon));
      chk_int("pulses", r.np, pulses - n0);
      chk_int("width", PULSE_TICKS * TC, width);
      // quiet left, sequencer idle: in the low byte only the per-period count field remains
      axi(1'b0, OFS_STATUS, 32'h0, q, rs);
      chk_bus("status_count", 32'(r.np) << STS_CNT, q & 32'hff);
    end
    axi(1'b0, 8'h14, 32'h0, q, rs);
    chk_bus("unmapped_rresp", 32'(RESP_SLVERR), 32'(rs));
    chk_bus("unmapped_rdata", 32'h0, q);
    axi(1'b1, 8'h20, 32'h1, q, rs);
    chk_bus("unmapped_bresp", 32'(RESP_SLVERR), 32'(rs));
    axi(1'b1, OFS_COUNT, 32'hffffffff, q, rs);
    axi(1'b0, OFS_COUNT, 32'h0, q, rs);
    chk_bus("count_field", 32'h7, q);
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_bus("trig_after_reset", 32'h1, 32'(mri_trig_n));
    axi(1'b0, OFS_CTRL, 32'h0, q, rs);
    chk_bus("ctrl_after_reset", 32'(CTRL_RST), q);
    axi(1'b0, OFS_COUNT, 32'h0, q, rs);
    chk_bus("count_after_reset", 32'(CNT_RST), q);
    end_of_test();
  end
endmodule
`default_nettype wire
